// ### logic/core_branch_pkg.sv
// Shared constants, types and decode helpers for the bit-invert and flag-branch unit.
// Assumes a core that splits each instruction cycle into four clock phases.
`default_nettype none
package core_branch_pkg;

    // Instruction encodings.
    localparam logic [3:0] BIT_INVERT_NIB    = 4'h7;
    localparam logic [7:0] BRANCH_OVF_BYTE   = 8'he4;
    localparam logic [7:0] BRANCH_ZERO_BYTE  = 8'he0;

    // Field positions inside the 16-bit instruction word.
    localparam int         OPC_NIB_LSB       = 12;
    localparam int         OPC_BYTE_LSB      = 8;
    localparam int         BIT_POS_LSB       = 9;
    localparam int         BANK_SEL_POS      = 8;

    // Access bank split: addresses below this map low, or index when extended.
    localparam logic [7:0] ACCESS_SPLIT      = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK    = 4'hf;

    // Program counter advance past a one-word instruction, in bytes.
    localparam int         PC_STEP           = 2;
    localparam int         PC_W_DEFAULT      = 21;
    localparam int         DADDR_W           = 12;

    // Reset values.
    localparam logic [7:0] DATA_RESET        = 8'h00;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } phase_t;

    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_INVERT = 2'b01,
        OP_BOV    = 2'b11,
        OP_BZ     = 2'b10
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [2:0] bit_pos;
        logic       bank_sel;
        logic [7:0] low_byte;
    } dec_t;

    typedef struct packed {
        logic ovf;
        logic zero;
    } flags_t;

    localparam dec_t DEC_IDLE = '{op: OP_NONE, bit_pos: 3'h0, bank_sel: 1'b0, low_byte: 8'h00};

    function automatic dec_t decode(input logic [15:0] word);
        dec_t d;
        d          = DEC_IDLE;
        d.bit_pos  = word[BIT_POS_LSB +: 3];
        d.bank_sel = word[BANK_SEL_POS];
        d.low_byte = word[7:0];
        if (word[OPC_NIB_LSB +: 4] == BIT_INVERT_NIB) begin
            d.op = OP_INVERT;
        end else if (word[OPC_BYTE_LSB +: 8] == BRANCH_OVF_BYTE) begin
            d.op = OP_BOV;
        end else if (word[OPC_BYTE_LSB +: 8] == BRANCH_ZERO_BYTE) begin
            d.op = OP_BZ;
        end
        return d;
    endfunction

    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        return 8'(8'h01 << pos);
    endfunction

    function automatic logic branch_taken(input op_t op, input flags_t f);
        return ((op == OP_BOV) && f.ovf) || ((op == OP_BZ) && f.zero);
    endfunction

endpackage
`default_nettype wire

// ### logic/operand_addr_gen.sv
// Forms the data-memory address of a bit-oriented register operand.
// Assumes bank select and index register values are stable in the decode phase.
`timescale 1ns/1ps
`default_nettype none
module operand_addr_gen
    import core_branch_pkg::*;
(
    input  wire logic [7:0]         fadr_in,
    input  wire logic               bank_sel_in,
    input  wire logic [3:0]         bsr_in,
    input  wire logic               ext_set_en_in,
    input  wire logic [DADDR_W-1:0] fsr2_in,
    output logic      [DADDR_W-1:0] addr_out
);

    always_comb begin
        if (!bank_sel_in && ext_set_en_in && (fadr_in < ACCESS_SPLIT)) begin
            addr_out = DADDR_W'(fsr2_in + {4'h0, fadr_in});
        end else if (!bank_sel_in) begin
            addr_out = (fadr_in < ACCESS_SPLIT) ? {4'h0, fadr_in} : {ACCESS_HI_BANK, fadr_in};
        end else begin
            addr_out = {bsr_in, fadr_in};
        end
    end

endmodule
`default_nettype wire

// ### logic/flag_branch_unit.sv
// Executes bit-invert and overflow/zero relative branches across four clock phases.
// Assumes fetch presents each instruction with its address in phase one, and that the
// data memory answers a read combinationally in the cycle the read strobe is high.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Top nibble 0111 decodes as bit invert.
// - Read register, flip one bit, write back.
// - Extended set, bank bit clear: index below 96.
// - Bank bit clear: access bank; set: banked.
// - Upper byte e4 decodes branch on overflow.
// - Overflow set loads pc plus two plus 2n.
// - Offset is signed words, doubled into bytes.
// - Upper byte e0 decodes branch on zero.
// - Zero branch taken only with zero flag.
// - Target counts from already advanced pc.
// - Taken branch adds one idle flushed cycle.
// - Decode, literal, process, pc write in phases.
module flag_branch_unit
    import core_branch_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
)(
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    input  wire logic               ce_in,
    input  wire logic               instr_valid_in,
    input  wire logic [15:0]        instr_in,
    input  wire logic [PC_W-1:0]    instr_addr_in,
    input  wire flags_t             flags_in,
    input  wire logic               ext_set_en_in,
    input  wire logic [3:0]         bsr_in,
    input  wire logic [DADDR_W-1:0] fsr2_in,
    input  wire logic [7:0]         dmem_rdata_in,
    output phase_t                  phase_out,
    output logic      [DADDR_W-1:0] dmem_addr_out,
    output logic                    dmem_rd_out,
    output logic                    dmem_wr_out,
    output logic      [7:0]         dmem_wdata_out,
    output logic                    pc_load_out,
    output logic      [PC_W-1:0]    pc_target_out,
    output logic                    flush_out,
    output logic                    flags_we_out
);

    // The sign-extended, doubled offset needs at least one bit above the byte field.
    if (PC_W < 10) begin : g_pc_w_check
        $error("flag_branch_unit: PC_W must be at least 10");
    end

    function automatic logic [PC_W-1:0] widen(input logic [7:0] n);
        return {{(PC_W-9){n[7]}}, n, 1'b0};
    endfunction

    phase_t              phase_ff;
    phase_t              nxt_phase;
    dec_t                dec_ff;
    dec_t                nxt_dec;
    dec_t                dec_now;
    logic [PC_W-1:0]     base_ff;
    logic [PC_W-1:0]     nxt_base;
    logic [PC_W-1:0]     disp_ff;
    logic [PC_W-1:0]     nxt_disp;
    logic [PC_W-1:0]     target_ff;
    logic [PC_W-1:0]     nxt_target;
    logic [DADDR_W-1:0]  addr_ff;
    logic [DADDR_W-1:0]  nxt_addr;
    logic [DADDR_W-1:0]  gen_addr;
    logic [7:0]          data_ff;
    logic [7:0]          nxt_data;
    logic [7:0]          wdata_ff;
    logic [7:0]          nxt_wdata;
    logic                rd_ff;
    logic                nxt_rd;
    logic                wr_ff;
    logic                nxt_wr;
    logic                load_ff;
    logic                nxt_load;
    logic                flush_ff;
    logic                nxt_flush;
    logic                accept;

    assign dec_now = decode(instr_in);
    // A discarded prefetch in the flush cycle is never decoded.
    assign accept  = instr_valid_in && !flush_ff;

    operand_addr_gen u_addr (
        .fadr_in       (dec_now.low_byte),
        .bank_sel_in   (dec_now.bank_sel),
        .bsr_in        (bsr_in),
        .ext_set_en_in (ext_set_en_in),
        .fsr2_in       (fsr2_in),
        .addr_out      (gen_addr)
    );

    always_comb begin
        nxt_phase  = phase_ff;
        nxt_dec    = dec_ff;
        nxt_base   = base_ff;
        nxt_disp   = disp_ff;
        nxt_target = target_ff;
        nxt_addr   = addr_ff;
        nxt_data   = data_ff;
        nxt_wdata  = wdata_ff;
        nxt_rd     = rd_ff;
        nxt_wr     = wr_ff;
        nxt_load   = load_ff;
        nxt_flush  = flush_ff;
        case (phase_ff)
            PH_Q1: begin
                nxt_phase = PH_Q2;
                nxt_dec   = accept ? dec_now : DEC_IDLE;
                nxt_base  = instr_addr_in;
                nxt_addr  = gen_addr;
                nxt_rd    = accept && (dec_now.op == OP_INVERT);
            end
            PH_Q2: begin
                nxt_phase = PH_Q3;
                nxt_rd    = 1'b0;
                if (dec_ff.op == OP_INVERT) begin
                    nxt_data = dmem_rdata_in;
                end
                nxt_disp  = widen(dec_ff.low_byte);
            end
            PH_Q3: begin
                nxt_phase = PH_Q4;
                nxt_wdata = data_ff ^ bit_mask(dec_ff.bit_pos);
                nxt_wr    = (dec_ff.op == OP_INVERT);
                nxt_target = PC_W'(base_ff + PC_W'(PC_STEP) + disp_ff);
                nxt_load  = branch_taken(dec_ff.op, flags_in);
            end
            PH_Q4: begin
                nxt_phase = PH_Q1;
                nxt_wr    = 1'b0;
                nxt_load  = 1'b0;
                // Idle cycle after a taken branch.
                nxt_flush = load_ff;
            end
            default: begin
                nxt_phase = PH_Q1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            phase_ff  <= PH_Q1;
            dec_ff    <= DEC_IDLE;
            base_ff   <= '0;
            disp_ff   <= '0;
            target_ff <= '0;
            addr_ff   <= '0;
            data_ff   <= DATA_RESET;
            wdata_ff  <= DATA_RESET;
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b0;
            load_ff   <= 1'b0;
            flush_ff  <= 1'b0;
        end else if (ce_in) begin
            phase_ff  <= nxt_phase;
            dec_ff    <= nxt_dec;
            base_ff   <= nxt_base;
            disp_ff   <= nxt_disp;
            target_ff <= nxt_target;
            addr_ff   <= nxt_addr;
            data_ff   <= nxt_data;
            wdata_ff  <= nxt_wdata;
            rd_ff     <= nxt_rd;
            wr_ff     <= nxt_wr;
            load_ff   <= nxt_load;
            flush_ff  <= nxt_flush;
        end
    end

    assign phase_out      = phase_ff;
    assign dmem_addr_out  = addr_ff;
    assign dmem_rd_out    = rd_ff;
    assign dmem_wr_out    = wr_ff;
    assign dmem_wdata_out = wdata_ff;
    assign pc_load_out    = load_ff;
    assign pc_target_out  = target_ff;
    assign flush_out      = flush_ff;
    assign flags_we_out   = 1'b0;

    // Checks run only on enabled edges, so a frozen core does not skew the delays.
    default clocking cb @(posedge ref_clk_in iff ce_in);
    endclocking
    default disable iff (rst_in);

    sequence s_issue_invert;
        (phase_out == PH_Q1) && instr_valid_in && !flush_out &&
        (instr_in[OPC_NIB_LSB +: 4] == BIT_INVERT_NIB);
    endsequence

    sequence s_issue_bov;
        (phase_out == PH_Q1) && instr_valid_in && !flush_out &&
        (instr_in[OPC_BYTE_LSB +: 8] == BRANCH_OVF_BYTE);
    endsequence

    sequence s_issue_bz;
        (phase_out == PH_Q1) && instr_valid_in && !flush_out &&
        (instr_in[OPC_BYTE_LSB +: 8] == BRANCH_ZERO_BYTE);
    endsequence

    sequence s_issue_other;
        (phase_out == PH_Q1) && instr_valid_in && !flush_out &&
        (instr_in[OPC_NIB_LSB +: 4] != BIT_INVERT_NIB) &&
        (instr_in[OPC_BYTE_LSB +: 8] != BRANCH_OVF_BYTE) &&
        (instr_in[OPC_BYTE_LSB +: 8] != BRANCH_ZERO_BYTE);
    endsequence

    sequence s_phase_walk;
        (phase_out == PH_Q2) ##1 (phase_out == PH_Q3) ##1
        (phase_out == PH_Q4) ##1 (phase_out == PH_Q1);
    endsequence

    a_invert_decode:
        assert property (s_issue_invert |=> dmem_rd_out ##2 dmem_wr_out)
        else $error("bit invert not decoded into read then write");

    a_rmw_flip:
        assert property (dmem_wr_out |->
            (dmem_wdata_out == ($past(dmem_rdata_in, 2) ^
                                bit_mask($past(instr_in[BIT_POS_LSB +: 3], 3)))))
        else $error("write back does not flip exactly the selected bit");

    a_rmw_same_addr:
        assert property (dmem_rd_out |-> ##2 (dmem_addr_out == $past(dmem_addr_out, 2)))
        else $error("write back address differs from read address");

    a_addr_bank:
        assert property (s_issue_invert ##0 instr_in[BANK_SEL_POS] |=>
            (dmem_addr_out == {$past(bsr_in), $past(instr_in[7:0])}))
        else $error("banked operand address wrong");

    a_addr_index:
        assert property (s_issue_invert ##0 (!instr_in[BANK_SEL_POS] && ext_set_en_in &&
            (instr_in[7:0] < ACCESS_SPLIT)) |=>
            (dmem_addr_out == DADDR_W'($past(fsr2_in) + {4'h0, $past(instr_in[7:0])})))
        else $error("indexed operand address wrong");

    a_bov_cond:
        assert property (s_issue_bov ##2 1'b1 |=> (pc_load_out == $past(flags_in.ovf)))
        else $error("overflow branch decision wrong");

    a_bz_cond:
        assert property (s_issue_bz ##2 1'b1 |=> (pc_load_out == $past(flags_in.zero)))
        else $error("zero branch decision wrong");

    a_target_math:
        assert property (pc_load_out |-> (pc_target_out ==
            PC_W'($past(instr_addr_in, 3) + PC_W'(PC_STEP) + widen($past(instr_in[7:0], 3)))))
        else $error("branch target not pc plus two plus doubled offset");

    a_load_phase:
        assert property (pc_load_out |-> (phase_out == PH_Q4))
        else $error("pc written outside phase four");

    a_flush_len:
        assert property (pc_load_out |=> flush_out [*4] ##1 !flush_out)
        else $error("taken branch idle cycle not exactly one instruction cycle");

    a_flush_quiet:
        assert property (flush_out |-> !dmem_rd_out && !dmem_wr_out && !pc_load_out)
        else $error("activity during the flushed cycle");

    a_flags_quiet:
        assert property (!flags_we_out)
        else $error("status flags written");

    a_bov_decode:
        assert property (s_issue_bov |=> (dec_ff.op == OP_BOV) && !dmem_rd_out &&
            (dec_ff.low_byte == $past(instr_in[7:0])))
        else $error("overflow branch not decoded with its offset");

    a_bz_decode:
        assert property (s_issue_bz |=> (dec_ff.op == OP_BZ) && !dmem_rd_out &&
            (dec_ff.low_byte == $past(instr_in[7:0])))
        else $error("zero branch not decoded with its offset");

    a_refuse_other:
        assert property (s_issue_other |=> !dmem_rd_out ##2 (!dmem_wr_out && !pc_load_out))
        else $error("unknown opcode caused activity");

    a_bov_fallthru:
        assert property (s_issue_bov ##2 !flags_in.ovf |=> !pc_load_out ##1 !flush_out)
        else $error("overflow branch taken with flag clear");

    a_bz_fallthru:
        assert property (s_issue_bz ##2 !flags_in.zero |=> !pc_load_out ##1 !flush_out)
        else $error("zero branch taken with flag clear");

    a_phase_order:
        assert property ((phase_out == PH_Q1) |=> s_phase_walk)
        else $error("instruction phases out of order");

    a_flush_discard:
        assert property ((phase_out == PH_Q1) && flush_out |=> (dec_ff.op == OP_NONE))
        else $error("prefetched word executed in the idle cycle");

endmodule
`default_nettype wire

// ### test/test_flag_branch_unit.sv
// Self-checking bench for the bit-invert and flag-branch unit.
// Assumes the bench plays fetch and data memory and drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_flag_branch_unit;
    import core_branch_pkg::*;

    logic              ref_clk_in;
    logic              rst_in;
    logic              ce_in;
    logic              instr_valid_in;
    logic [15:0]       instr_in;
    logic [20:0]       instr_addr_in;
    flags_t            flags_in;
    logic              ext_set_en_in;
    logic [3:0]        bsr_in;
    logic [11:0]       fsr2_in;
    logic [7:0]        dmem_rdata_in;
    phase_t            phase_out;
    logic [11:0]       dmem_addr_out;
    logic              dmem_rd_out;
    logic              dmem_wr_out;
    logic [7:0]        dmem_wdata_out;
    logic              pc_load_out;
    logic [20:0]       pc_target_out;
    logic              flush_out;
    logic              flags_we_out;
    int                fail_count;
    int                samples_checked;

    flag_branch_unit #(.PC_W(21)) DUT (
        .ref_clk_in     (ref_clk_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .instr_valid_in (instr_valid_in),
        .instr_in       (instr_in),
        .instr_addr_in  (instr_addr_in),
        .flags_in       (flags_in),
        .ext_set_en_in  (ext_set_en_in),
        .bsr_in         (bsr_in),
        .fsr2_in        (fsr2_in),
        .dmem_rdata_in  (dmem_rdata_in),
        .phase_out      (phase_out),
        .dmem_addr_out  (dmem_addr_out),
        .dmem_rd_out    (dmem_rd_out),
        .dmem_wr_out    (dmem_wr_out),
        .dmem_wdata_out (dmem_wdata_out),
        .pc_load_out    (pc_load_out),
        .pc_target_out  (pc_target_out),
        .flush_out      (flush_out),
        .flags_we_out   (flags_we_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The target counts from the already advanced address, offset doubled.
    function automatic logic [20:0] tgt(input logic [20:0] a, input logic [7:0] n);
        return a + 21'h2 + {{12{n[7]}}, n, 1'b0};
    endfunction

    // Walks one instruction through its four phases; on a taken branch a stray
    // instruction is offered in the idle cycle, and it must come to nothing.
    task automatic run_op(input logic [15:0] w, input logic [20:0] ia, input logic [1:0] fl,
                          input logic [7:0] rdv, input logic [11:0] ea,
                          input logic inv, input logic tk);
        for (int n = 0; n < 8 && phase_out !== PH_Q1; n++) @(negedge ref_clk_in);
        instr_valid_in = 1'b1;
        instr_in = w;
        instr_addr_in = ia;
        flags_in = flags_t'(fl);
        @(negedge ref_clk_in);
        instr_valid_in = 1'b0;
        instr_in = ~w;
        dmem_rdata_in = rdv;
        check(32'(phase_out), 32'(PH_Q2)); // phase order
        check(32'(dmem_rd_out), 32'(inv)); // decode
        if (inv) check(32'(dmem_addr_out), 32'(ea)); // operand address
        @(negedge ref_clk_in);
        dmem_rdata_in = ~rdv;
        check(32'(dmem_rd_out), 32'h0); // single read
        @(negedge ref_clk_in);
        flags_in = flags_t'(~fl);
        check(32'(dmem_wr_out), 32'(inv)); // write back
        if (inv) check(32'(dmem_wdata_out), 32'(rdv ^ (8'h01 << w[11:9]))); // one bit
        check(32'(pc_load_out), 32'(tk)); // condition
        if (tk) check(32'(pc_target_out), 32'(tgt(ia, w[7:0])));
        check(32'(flags_we_out), 32'h0); // flags kept
        @(negedge ref_clk_in);
        check(32'(dmem_wr_out | pc_load_out), 32'h0); // strobes one clock
        check(32'(flush_out), 32'(tk)); // idle cycle
        if (tk) begin
            instr_valid_in = 1'b1;
            instr_in = 16'h7000;
            for (int i = 0; i < 3; i++) begin
                @(negedge ref_clk_in);
                instr_valid_in = 1'b0;
                check(32'({flush_out, dmem_rd_out, pc_load_out}), 32'h4); // discard
            end
            @(negedge ref_clk_in);
            check(32'({flush_out, dmem_rd_out}), 32'h0); // one idle instruction cycle only
        end
    endtask

    task automatic test_invert();
        ext_set_en_in = 1'b0;
        bsr_in = 4'h3;
        for (int b = 0; b < 8; b++) begin
            run_op({4'h7, 3'(b), 1'b1, 8'ha5}, 21'h0, 2'b11, b[0] ? 8'h8a : 8'h75,
                   12'h3a5, 1'b1, 1'b0);
        end
        $display("test_invert done");
    endtask

    task automatic test_address();
        logic [7:0]  f [6]  = '{8'h20, 8'h60, 8'h5f, 8'h60, 8'h10, 8'h05};
        logic        e [6]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic        a [6]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic [3:0]  k [6]  = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h9};
        logic [11:0] ea [6] = '{12'h020, 12'hf60, 12'h059, 12'hf60, 12'h310, 12'h905};
        fsr2_in = 12'hffa;
        for (int i = 0; i < 6; i++) begin
            ext_set_en_in = e[i];
            bsr_in = k[i];
            run_op({4'h7, 3'h4, a[i], f[i]}, 21'h0, 2'b00, 8'h75, ea[i], 1'b1, 1'b0);
        end
        $display("test_address done");
    endtask

    task automatic test_branch();
        logic [15:0] w [7]  = '{16'he480, 16'he47f, 16'he0fe, 16'he401, 16'he410, 16'he010,
                                16'he001};
        logic [20:0] ia [7] = '{21'h00400, 21'h00400, 21'h01000, 21'h1ffffe, 21'h00200,
                                21'h00200, 21'h00300};
        logic [1:0]  fl [7] = '{2'b10, 2'b11, 2'b01, 2'b10, 2'b01, 2'b10, 2'b11};
        logic        tk [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            run_op(w[i], ia[i], fl[i], 8'h00, 12'h000, 1'b0, tk[i]);
        end
        $display("test_branch done");
    endtask

    task automatic test_refuse();
        logic [15:0] w [4] = '{16'h1234, 16'he100, 16'h6f00, 16'he5ff};
        for (int i = 0; i < 4; i++) begin
            run_op(w[i], 21'h00100, 2'b11, 8'h33, 12'h000, 1'b0, 1'b0);
        end
        $display("test_refuse done");
    endtask

    // A low enable must freeze the read and the write phases without losing data.
    task automatic test_freeze();
        for (int n = 0; n < 8 && phase_out !== PH_Q1; n++) @(negedge ref_clk_in);
        ext_set_en_in = 1'b0;
        bsr_in = 4'h5;
        instr_valid_in = 1'b1;
        instr_in = {4'h7, 3'h2, 1'b1, 8'h11};
        instr_addr_in = 21'h0;
        @(negedge ref_clk_in);
        instr_valid_in = 1'b0;
        dmem_rdata_in = 8'hf0;
        ce_in = 1'b0;
        repeat (3) begin
            @(negedge ref_clk_in);
            check(32'({phase_out, dmem_rd_out}), 32'h3); // read held
        end
        check(32'(dmem_addr_out), 32'h511); // banked address
        ce_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        ce_in = 1'b0;
        check(32'({dmem_wr_out, dmem_wdata_out}), 32'h1f4); // bit two flipped
        repeat (2) @(negedge ref_clk_in);
        check(32'({phase_out, dmem_wr_out}), 32'h5); // write held
        ce_in = 1'b1;
        @(negedge ref_clk_in);
        check(32'({phase_out, dmem_wr_out}), 32'h0); // back to phase one
        $display("test_freeze done");
    endtask

    // A reset inside the idle cycle must clear it, and work resumes at once.
    task automatic test_reset();
        for (int n = 0; n < 8 && phase_out !== PH_Q1; n++) @(negedge ref_clk_in);
        instr_valid_in = 1'b1;
        instr_in = 16'he002;
        instr_addr_in = 21'h00100;
        flags_in = flags_t'(2'b01);
        @(negedge ref_clk_in);
        instr_valid_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(32'({flush_out, pc_load_out}), 32'h1); // zero branch taken
        check(32'(pc_target_out), 32'h00106); // target
        @(negedge ref_clk_in);
        check(32'(flush_out), 32'h1); // idle cycle begun
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        check(32'({phase_out, flush_out, pc_load_out, dmem_rd_out, dmem_wr_out}), 32'h0);
        check(32'(pc_target_out), 32'h0); // target cleared
        rst_in = 1'b0;
        run_op({4'h7, 3'h0, 1'b0, 8'h80}, 21'h0, 2'b01, 8'h01, 12'hf80, 1'b1, 1'b0);
        $display("test_reset done");
    endtask

    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        instr_valid_in = 1'b0;
        instr_in = 16'h0000;
        instr_addr_in = 21'h0;
        flags_in = flags_t'(2'b00);
        ext_set_en_in = 1'b0;
        bsr_in = 4'h0;
        fsr2_in = 12'h000;
        dmem_rdata_in = 8'h00;
        repeat (10) @(negedge ref_clk_in);
        rst_in = 1'b0;
        test_invert();
        test_address();
        test_branch();
        test_refuse();
        test_freeze();
        test_reset();
        close_out();
    end

    // The whole run needs about 150 clocks; this span is ample margin.
    initial begin
        repeat (4000) @(posedge ref_clk_in);
        fail_count++;
        close_out();
    end

endmodule
`default_nettype wire
